/* verilog/qpgcr_global_regs.sv */
// Overview of operation
// - control bit 0 selects cell mode at zero, packet mode at one
// - control bit 1 picks byte-level or packet-level transfer in packet mode
// - enable bit zero floats system outputs except packet-available outputs
// - device address matching bus address bits 4:2 selects channel by bits 1:0
// - bus address all ones is null; no channel answers it
// - clock flags set on rising edge, stick, cleared together by reading
// - monitor bits: ref, tx fifo, rx fifo, tx line, recovered clocks 1-4
// - summary bits 0-3 show pending interrupt of channels 1-4
// - summary bit 4 shows pending clock synthesis interrupt
// - interrupt output pin driven low while any source pending
// - write to channel reset register with reset zero starts counter transfer
// - transfer flag stays high until counter transfer completes
// - channel reset bit holds channel in reset until written zero
// - hardware reset clears channel reset bits
// - channel 1 reset blocks access to global offsets zero to four
// - receiver level bit selects 3.3 V at zero, 5.0 V at one
`timescale 1ns/1ns
`default_nettype none
module qpgcr_global_regs #(
	parameter int NUM_CH = qpgcr_pkg::QPGCR_NUM_CH
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// microprocessor register port
	input wire logic cs_n_in,
	input wire logic rd_n_in,
	input wire logic wr_n_in,
	input wire logic [qpgcr_pkg::QPGCR_ADDR_W-1:0] addr_in,
	input wire logic [qpgcr_pkg::QPGCR_DATA_W-1:0] data_in,
	output logic [qpgcr_pkg::QPGCR_DATA_W-1:0] data_out,
	output logic data_oe_out,
	// monitored clocks
	input wire logic reference_clock_in,
	input wire logic tx_fifo_clock_in,
	input wire logic rx_fifo_clock_in,
	input wire logic tx_line_clock_in,
	input wire logic [NUM_CH-1:0] recovered_clock_in,
	// interrupt sources and pin
	input wire logic [NUM_CH-1:0] channel_irq_pending_in,
	input wire logic clock_synth_irq_pending_in,
	output logic irq_out_n,
	// system interface
	input wire logic [qpgcr_pkg::QPGCR_BUS_ADDR_W-1:0] transmit_bus_address_in,
	input wire logic [qpgcr_pkg::QPGCR_BUS_ADDR_W-1:0] receive_bus_address_in,
	output logic [NUM_CH-1:0] tx_channel_select_out,
	output logic [NUM_CH-1:0] rx_channel_select_out,
	output logic cell_or_packet_mode_out,
	output logic packet_transfer_granularity_out,
	output logic sys_if_output_enable_out,
	output logic packet_available_output_enable_out,
	output logic receiver_level_select_out,
	// channel control
	output logic [NUM_CH-1:0] channel_soft_reset_out,
	output logic [NUM_CH-1:0] counter_transfer_start_out,
	output logic [NUM_CH-1:0] counter_transfer_in_progress_out,
	input wire logic [NUM_CH-1:0] counter_transfer_done_in
);
	import qpgcr_pkg::*;

	localparam int PIN_W = QPGCR_STROBE_W + QPGCR_ADDR_W + QPGCR_DATA_W + 2 * QPGCR_BUS_ADDR_W;
	localparam logic [PIN_W-1:0] PIN_IDLE = {QPGCR_STROBE_IDLE, {(PIN_W-QPGCR_STROBE_W){1'b0}}};

	logic [PIN_W-1:0] pin_meta;
	logic [PIN_W-1:0] pin_sync;
	logic cs_n_s;
	logic rd_n_s;
	logic wr_n_s;
	logic [QPGCR_ADDR_W-1:0] addr_s;
	logic [QPGCR_DATA_W-1:0] wdata_s;
	logic [QPGCR_BUS_ADDR_W-1:0] transmit_bus_address_s;
	logic [QPGCR_BUS_ADDR_W-1:0] receive_bus_address_s;

	qpgcr_bus_state_e state;
	qpgcr_bus_state_e next_state;
	logic [QPGCR_ADDR_W-1:0] acc_addr;
	logic [QPGCR_DATA_W-1:0] acc_data;
	logic [QPGCR_DATA_W-1:0] next_rdata;
	logic write_commit;
	logic read_done;

	logic [QPGCR_DATA_W-1:0] master_cfg;
	logic [QPGCR_DATA_W-1:0] sys_if_ctrl;
	logic [QPGCR_DATA_W-1:0] irq_summary;
	logic clk_clear;
	logic [QPGCR_DEV_ADDR_W-1:0] dev_addr;

	qpgcr_clkmon_if mon_if();

	////////////////////////////////////////////////////////////////////////
	// decode helpers
	function automatic logic [1:0] page_of(input logic [QPGCR_ADDR_W-1:0] a);
		return a[QPGCR_PAGE_MSB:QPGCR_PAGE_LSB];
	endfunction

	function automatic logic [7:0] off_of(input logic [QPGCR_ADDR_W-1:0] a);
		return a[QPGCR_OFF_MSB:0];
	endfunction

	function automatic logic is_blocked(input logic [QPGCR_ADDR_W-1:0] a, input logic ch1_rst);
		return a[QPGCR_TEST_SEL_BIT] ||
			(ch1_rst && page_of(a) == QPGCR_PAGE_CH1 && off_of(a) <= QPGCR_OFF_GLOBAL_LAST);
	endfunction

	function automatic logic is_global(input logic [QPGCR_ADDR_W-1:0] a, input logic [7:0] off);
		return page_of(a) == QPGCR_PAGE_CH1 && off_of(a) == off;
	endfunction

	function automatic logic [NUM_CH-1:0] match_sel(
		input logic [QPGCR_BUS_ADDR_W-1:0] a,
		input logic [QPGCR_DEV_ADDR_W-1:0] dev,
		input logic en
	);
		logic [NUM_CH-1:0] sel;
		sel = '0;
		if (en && a != QPGCR_NULL_BUS_ADDR && a[QPGCR_BUS_ADDR_W-1:QPGCR_BUS_CH_LSB] == dev) begin
			sel = NUM_CH'(QPGCR_ONE_CH << a[QPGCR_CH_SEL_W-1:0]);
		end
		return sel;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pin_meta <= PIN_IDLE;
			pin_sync <= PIN_IDLE;
		end else begin
			pin_meta <= {cs_n_in, rd_n_in, wr_n_in, addr_in, data_in,
				transmit_bus_address_in, receive_bus_address_in};
			pin_sync <= pin_meta;
		end
	end

	assign {cs_n_s, rd_n_s, wr_n_s, addr_s, wdata_s, transmit_bus_address_s, receive_bus_address_s} = pin_sync;

	////////////////////////////////////////////////////////////////////////
	// access state machine
	always_comb begin
		next_state = state;
		unique case (state)
			QPGCR_BUS_IDLE: begin
				if (!cs_n_s && !rd_n_s) begin
					next_state = QPGCR_BUS_READ;
				end else if (!cs_n_s && !wr_n_s) begin
					next_state = QPGCR_BUS_WRITE;
				end
			end
			QPGCR_BUS_READ: begin
				if (rd_n_s || cs_n_s) begin
					next_state = QPGCR_BUS_IDLE;
				end
			end
			QPGCR_BUS_WRITE: begin
				if (wr_n_s || cs_n_s) begin
					next_state = QPGCR_BUS_IDLE;
				end
			end
			default: begin
				next_state = QPGCR_BUS_IDLE;
			end
		endcase
	end

	assign write_commit = state == QPGCR_BUS_WRITE && next_state == QPGCR_BUS_IDLE;
	assign read_done = state == QPGCR_BUS_READ && next_state == QPGCR_BUS_IDLE;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state <= QPGCR_BUS_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// address and data held from the strobe's active phase
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			acc_addr <= '0;
			acc_data <= '0;
		end else if (next_state != QPGCR_BUS_IDLE) begin
			acc_addr <= addr_s;
			acc_data <= wdata_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data
	always_comb begin
		next_rdata = '0;
		if (!is_blocked(addr_s, channel_soft_reset_out[0])) begin
			if (off_of(addr_s) == QPGCR_OFF_CH_RESET) begin
				next_rdata[QPGCR_BIT_CH_RESET] = channel_soft_reset_out[page_of(addr_s)];
				next_rdata[QPGCR_BIT_TIP] = counter_transfer_in_progress_out[page_of(addr_s)];
			end else if (is_global(addr_s, QPGCR_OFF_MASTER_CFG)) begin
				next_rdata = master_cfg;
			end else if (is_global(addr_s, QPGCR_OFF_SYS_IF_CTRL)) begin
				next_rdata = sys_if_ctrl;
			end else if (is_global(addr_s, QPGCR_OFF_CLK_MON)) begin
				next_rdata = mon_if.flags;
			end else if (is_global(addr_s, QPGCR_OFF_IRQ_SUM)) begin
				next_rdata = irq_summary;
			end
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			data_out <= '0;
			data_oe_out <= 1'b0;
		end else begin
			data_out <= next_rdata;
			data_oe_out <= next_state == QPGCR_BUS_READ;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// clock monitor and its clear-on-read
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			clk_clear <= 1'b0;
		end else begin
			clk_clear <= read_done && is_global(acc_addr, QPGCR_OFF_CLK_MON) &&
				!is_blocked(acc_addr, channel_soft_reset_out[0]);
		end
	end

	assign mon_if.clear = clk_clear;

	qpgcr_clock_monitor #(
		.NUM_CLK(QPGCR_NUM_CLK)
	) u_clock_monitor (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.mon_clocks_in({recovered_clock_in, tx_line_clock_in, rx_fifo_clock_in,
			tx_fifo_clock_in, reference_clock_in}),
		.mon(mon_if.monitor)
	);

	////////////////////////////////////////////////////////////////////////
	// global configuration registers; monitor and summary ignore writes
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			master_cfg <= QPGCR_MASTER_CFG_RESET;
			sys_if_ctrl <= QPGCR_SYS_IF_RESET;
		end else if (write_commit && !is_blocked(acc_addr, channel_soft_reset_out[0])) begin
			if (is_global(acc_addr, QPGCR_OFF_MASTER_CFG)) begin
				master_cfg <= acc_data;
			end
			if (is_global(acc_addr, QPGCR_OFF_SYS_IF_CTRL)) begin
				sys_if_ctrl <= acc_data & QPGCR_SYS_IF_WMASK;
			end
		end
	end

	assign dev_addr = sys_if_ctrl[QPGCR_DEV_ADDR_LSB +: QPGCR_DEV_ADDR_W];
	assign cell_or_packet_mode_out = sys_if_ctrl[QPGCR_BIT_MODE];
	assign packet_transfer_granularity_out = sys_if_ctrl[QPGCR_BIT_GRAN];
	assign sys_if_output_enable_out = sys_if_ctrl[QPGCR_BIT_ENABLE];
	assign receiver_level_select_out = master_cfg[QPGCR_BIT_RX_LEVEL];

	// packet-available outputs stay driven regardless of enable
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			packet_available_output_enable_out <= 1'b0;
		end else begin
			packet_available_output_enable_out <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// system bus address matching
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tx_channel_select_out <= '0;
			rx_channel_select_out <= '0;
		end else begin
			tx_channel_select_out <= match_sel(transmit_bus_address_s, dev_addr, sys_if_ctrl[QPGCR_BIT_ENABLE]);
			rx_channel_select_out <= match_sel(receive_bus_address_s, dev_addr, sys_if_ctrl[QPGCR_BIT_ENABLE]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt summary and pin
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			irq_summary <= '0;
			irq_out_n <= 1'b1;
		end else begin
			irq_summary <= QPGCR_DATA_W'({clock_synth_irq_pending_in, channel_irq_pending_in});
			irq_out_n <= !(clock_synth_irq_pending_in || |channel_irq_pending_in);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// per-channel soft reset and counter transfer
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			channel_soft_reset_out <= '0;
		end else begin
			for (int ch = 0; ch < NUM_CH; ch++) begin
				if (write_commit && !acc_addr[QPGCR_TEST_SEL_BIT] && page_of(acc_addr) == ch[1:0] &&
					off_of(acc_addr) == QPGCR_OFF_CH_RESET) begin
					channel_soft_reset_out[ch] <= acc_data[QPGCR_BIT_CH_RESET];
				end
			end
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			counter_transfer_start_out <= '0;
			counter_transfer_in_progress_out <= '0;
		end else begin
			for (int ch = 0; ch < NUM_CH; ch++) begin
				counter_transfer_start_out[ch] <= 1'b0;
				if (write_commit && !acc_addr[QPGCR_TEST_SEL_BIT] && page_of(acc_addr) == ch[1:0] &&
					off_of(acc_addr) == QPGCR_OFF_CH_RESET && !acc_data[QPGCR_BIT_CH_RESET]) begin
					counter_transfer_start_out[ch] <= 1'b1;
					counter_transfer_in_progress_out[ch] <= 1'b1;
				end else if (counter_transfer_done_in[ch]) begin
					counter_transfer_in_progress_out[ch] <= 1'b0;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* verilog/qpgcr_pkg.sv */
package qpgcr_pkg;

	// widths
	localparam int QPGCR_ADDR_W = 11;
	localparam int QPGCR_DATA_W = 8;
	localparam int QPGCR_NUM_CH = 4;
	localparam int QPGCR_NUM_CLK = 8;
	localparam int QPGCR_BUS_ADDR_W = 5;
	localparam int QPGCR_DEV_ADDR_W = 3;
	localparam int QPGCR_CH_SEL_W = 2;
	localparam int QPGCR_STROBE_W = 3;

	// address fields
	localparam int QPGCR_TEST_SEL_BIT = 10;
	localparam int QPGCR_PAGE_MSB = 9;
	localparam int QPGCR_PAGE_LSB = 8;
	localparam int QPGCR_OFF_MSB = 7;

	// register offsets within a page
	localparam logic [7:0] QPGCR_OFF_MASTER_CFG = 8'h01;
	localparam logic [7:0] QPGCR_OFF_SYS_IF_CTRL = 8'h02;
	localparam logic [7:0] QPGCR_OFF_CLK_MON = 8'h03;
	localparam logic [7:0] QPGCR_OFF_IRQ_SUM = 8'h04;
	localparam logic [7:0] QPGCR_OFF_CH_RESET = 8'h05;
	localparam logic [7:0] QPGCR_OFF_GLOBAL_LAST = 8'h04;
	localparam logic [1:0] QPGCR_PAGE_CH1 = 2'h0;

	// field positions
	localparam int QPGCR_BIT_MODE = 0;
	localparam int QPGCR_BIT_GRAN = 1;
	localparam int QPGCR_BIT_ENABLE = 4;
	localparam int QPGCR_DEV_ADDR_LSB = 5;
	localparam int QPGCR_BIT_RX_LEVEL = 7;
	localparam int QPGCR_BIT_CH_RESET = 7;
	localparam int QPGCR_BIT_TIP = 0;
	localparam int QPGCR_BUS_CH_LSB = 2;

	// reset values and masks
	localparam logic [7:0] QPGCR_MASTER_CFG_RESET = 8'h03;
	localparam logic [7:0] QPGCR_SYS_IF_RESET = 8'h00;
	localparam logic [7:0] QPGCR_SYS_IF_WMASK = 8'hF7;
	localparam logic [4:0] QPGCR_NULL_BUS_ADDR = 5'h1F;
	localparam logic [2:0] QPGCR_STROBE_IDLE = 3'h7;
	localparam logic [3:0] QPGCR_ONE_CH = 4'h1;

	// register port access state
	typedef enum logic [1:0] {
		QPGCR_BUS_IDLE = 2'b00,
		QPGCR_BUS_READ = 2'b01,
		QPGCR_BUS_WRITE = 2'b10
	} qpgcr_bus_state_e;

endpackage

/* verilog/qpgcr_clkmon_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface qpgcr_clkmon_if;
	import qpgcr_pkg::*;
	logic [QPGCR_NUM_CLK-1:0] flags;
	logic clear;
	modport monitor(input clear, output flags);
	modport owner(input flags, output clear);
endinterface
`default_nettype wire

/* verilog/qpgcr_clock_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module qpgcr_clock_monitor #(
	parameter int NUM_CLK = qpgcr_pkg::QPGCR_NUM_CLK
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// watched clocks
	input wire logic [NUM_CLK-1:0] mon_clocks_in,
	// flags to register file
	qpgcr_clkmon_if.monitor mon
);
	import qpgcr_pkg::*;

	logic [NUM_CLK-1:0] clk_meta;
	logic [NUM_CLK-1:0] clk_sync;
	logic [NUM_CLK-1:0] clk_prev;
	logic [NUM_CLK-1:0] flags;

	////////////////////////////////////////////////////////////////////////
	// two-flop synchronisers
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			clk_meta <= '0;
			clk_sync <= '0;
			clk_prev <= '0;
		end else begin
			clk_meta <= mon_clocks_in;
			clk_sync <= clk_meta;
			clk_prev <= clk_sync;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sticky rise flags, set wins over clear
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			flags <= '0;
		end else begin
			flags <= (clk_sync & ~clk_prev) | (flags & ~{NUM_CLK{mon.clear}});
		end
	end

	assign mon.flags = flags;
endmodule
`default_nettype wire

/* testbench/qpgcr_global_regs_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module qpgcr_global_regs_checker #(
	parameter int NUM_CH = 4
) (
	// clock, reset and write strobe
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic wr_n_in,
	// interrupts
	input wire logic [NUM_CH-1:0] channel_irq_pending_in,
	input wire logic clock_synth_irq_pending_in,
	input wire logic irq_out_n,
	// system interface
	input wire logic [qpgcr_pkg::QPGCR_BUS_ADDR_W-1:0] transmit_bus_address_in,
	input wire logic [NUM_CH-1:0] tx_channel_select_out,
	input wire logic cell_or_packet_mode_out,
	input wire logic sys_if_output_enable_out,
	// channel control
	input wire logic [NUM_CH-1:0] channel_soft_reset_out,
	input wire logic [NUM_CH-1:0] counter_transfer_start_out,
	input wire logic [NUM_CH-1:0] counter_transfer_in_progress_out,
	input wire logic [NUM_CH-1:0] counter_transfer_done_in
);
	import qpgcr_pkg::*;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	////////////////////////////////////////
	a_irq_pin_low: assert property (
		(|channel_irq_pending_in || clock_synth_irq_pending_in) |=> !irq_out_n)
		else $error("irq pin high with a source pending");
	a_null_addr: assert property (
		(transmit_bus_address_in == QPGCR_NULL_BUS_ADDR)[*4] |-> tx_channel_select_out == '0)
		else $error("null address selected a channel");
	a_sel_decode: assert property (
		$stable(transmit_bus_address_in)[*4] ##0 tx_channel_select_out != '0
		|-> tx_channel_select_out == (QPGCR_ONE_CH << transmit_bus_address_in[1:0]))
		else $error("wrong channel selected");
	a_sel_disabled: assert property (
		!sys_if_output_enable_out[*4] |-> tx_channel_select_out == '0)
		else $error("channel selected while interface off");
	a_tip_start: assert property (
		(counter_transfer_start_out & ~counter_transfer_in_progress_out) == '0)
		else $error("transfer started without busy flag");
	a_tip_hold: assert property (
		(~counter_transfer_in_progress_out
		& $past(counter_transfer_in_progress_out & ~counter_transfer_done_in)) == '0)
		else $error("busy flag dropped before done");
	a_tip_clear: assert property (
		(counter_transfer_in_progress_out & ~counter_transfer_start_out
		& $past(counter_transfer_in_progress_out & counter_transfer_done_in)) == '0)
		else $error("busy flag stuck after done");
	a_start_once: assert property (
		(counter_transfer_start_out & $past(counter_transfer_start_out)) == '0)
		else $error("transfer start longer than one cycle");
	a_tip_rise: assert property (
		(counter_transfer_in_progress_out & ~$past(counter_transfer_in_progress_out)
		& ~counter_transfer_start_out) == '0)
		else $error("busy flag rose without a start");
	a_ctrl_stable: assert property (
		wr_n_in[*6] |-> $stable({channel_soft_reset_out, cell_or_packet_mode_out}))
		else $error("control bits changed without a write");
endmodule
`default_nettype wire

/* testbench/qpgcr_cpu_model.sv */
`timescale 1ns/1ns
`default_nettype none
module qpgcr_cpu_model (
	// clock
	input wire logic clk_in,
	// register port
	output logic cs_n_out,
	output logic rd_n_out,
	output logic wr_n_out,
	output logic [qpgcr_pkg::QPGCR_ADDR_W-1:0] addr_out,
	output logic [qpgcr_pkg::QPGCR_DATA_W-1:0] wdata_out,
	input wire logic [qpgcr_pkg::QPGCR_DATA_W-1:0] rdata_in,
	input wire logic data_oe_in
);
	import qpgcr_pkg::*;
	initial begin
		cs_n_out = 1'b1;
		rd_n_out = 1'b1;
		wr_n_out = 1'b1;
		addr_out = '0;
		wdata_out = '0;
	end
	// one access; strobes low and high long enough for the synchronisers
	task automatic acc(input logic w, input logic [QPGCR_ADDR_W-1:0] a,
		input logic [QPGCR_DATA_W-1:0] d, output logic [QPGCR_DATA_W-1:0] q);
		int n;
		n = 0;
		q = 8'hXX;
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		cs_n_out <= 1'b0;
		rd_n_out <= w;
		wr_n_out <= !w;
		repeat (4) @(posedge clk_in);
		@(negedge clk_in);
		while (!w && data_oe_in !== 1'b1 && n < 20) begin
			@(negedge clk_in);
			n++;
		end
		if (!w && n < 20) begin
			q = rdata_in;
		end
		@(posedge clk_in);
		cs_n_out <= 1'b1;
		rd_n_out <= 1'b1;
		wr_n_out <= 1'b1;
		wdata_out <= ~d;
		repeat (4) @(posedge clk_in);
		@(negedge clk_in);
	endtask
endmodule
`default_nettype wire

/* testbench/qpgcr_global_regs_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module qpgcr_global_regs_tb;
	import qpgcr_pkg::*;
	localparam int NUM_CH = 4;
	logic clk_in;
	logic reset_n_in;
	logic cs_n, rd_n, wr_n, oe, irq_n, mode, gran, sysoe, paoe, rxl, synth;
	logic [10:0] addr;
	logic [7:0] wdata, rdata, mclk;
	logic [3:0] irq, tsel, rsel, srst, start, counter_transfer_in_progress, done;
	logic [4:0] taddr, raddr;
	int n_errors = 0;
	int total_checks = 0;
	qpgcr_global_regs #(.NUM_CH(NUM_CH)) dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n), .addr_in(addr), .data_in(wdata),
		.data_out(rdata), .data_oe_out(oe), .reference_clock_in(mclk[0]),
		.tx_fifo_clock_in(mclk[1]), .rx_fifo_clock_in(mclk[2]), .tx_line_clock_in(mclk[3]),
		.recovered_clock_in(mclk[7:4]), .channel_irq_pending_in(irq),
		.clock_synth_irq_pending_in(synth), .irq_out_n(irq_n),
		.transmit_bus_address_in(taddr), .receive_bus_address_in(raddr),
		.tx_channel_select_out(tsel), .rx_channel_select_out(rsel),
		.cell_or_packet_mode_out(mode), .packet_transfer_granularity_out(gran),
		.sys_if_output_enable_out(sysoe), .packet_available_output_enable_out(paoe),
		.receiver_level_select_out(rxl), .channel_soft_reset_out(srst),
		.counter_transfer_start_out(start), .counter_transfer_in_progress_out(counter_transfer_in_progress),
		.counter_transfer_done_in(done));
	qpgcr_cpu_model cpu (.clk_in(clk_in), .cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n),
		.addr_out(addr), .wdata_out(wdata), .rdata_in(rdata), .data_oe_in(oe));
	////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [10:0] a, input logic [7:0] d);
		logic [7:0] q;
		cpu.acc(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [10:0] a, input logic [7:0] e);
		logic [7:0] q;
		cpu.acc(1'b0, a, 8'h00, q);
		chk(q, e);
	endtask
	task automatic results;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	initial begin
		repeat (5000) @(posedge clk_in);
		n_errors++;
		$display("[FAIL] %0t ns: watchdog expired", $time);
		results();
	end
	initial begin
		reset_n_in = 1'b0;
		mclk = '0;
		irq = '0;
		synth = 1'b0;
		done = '0;
		taddr = 5'h1F;
		raddr = 5'h1F;
		repeat (20) @(posedge clk_in);
		reset_n_in <= 1'b1;
		repeat (2) @(negedge clk_in);
		chk({irq_n, paoe, sysoe, mode, gran, rxl, 2'b00}, 8'hC0);
		rd(11'h002, 8'h00);
		rd(11'h001, 8'h03);
		wr(11'h001, 8'h83);
		chk(8'(rxl), 8'h01);
		for (int i = 0; i < 4; i++) begin
			wr(11'h002, 8'(i));
			rd(11'h002, 8'(i));
			chk(8'({gran, mode}), 8'(i));
		end
		// address match, off then on
		wr(11'h002, 8'h60);
		@(posedge clk_in);
		taddr <= 5'h0E;
		raddr <= 5'h0D;
		repeat (5) @(negedge clk_in);
		chk({tsel, rsel}, 8'h00);
		wr(11'h002, 8'h70);
		chk({tsel, rsel}, 8'h42);
		wr(11'h002, 8'hF0);
		@(posedge clk_in);
		taddr <= 5'h1F;
		raddr <= 5'h1E;
		repeat (5) @(negedge clk_in);
		chk({tsel, rsel}, 8'h04);
		wr(11'h002, 8'hE0);
		chk({tsel, rsel}, 8'h00);
		chk({6'h00, sysoe, paoe}, 8'h01);
		// clock activity, one clock at a time
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_in);
			mclk[i] <= 1'b1;
			repeat (3) @(posedge clk_in);
			mclk[i] <= 1'b0;
			wr(11'h003, 8'h00);
			rd(11'h003, 8'(1 << i));
			rd(11'h003, 8'h00);
		end
		rd(11'h003, 8'h00);
		// interrupt summary
		@(posedge clk_in);
		irq <= 4'h5;
		synth <= 1'b1;
		repeat (2) @(negedge clk_in);
		chk(8'(irq_n), 8'h00);
		wr(11'h004, 8'h00);
		rd(11'h004, 8'h15);
		@(posedge clk_in);
		irq <= 4'hA;
		synth <= 1'b0;
		rd(11'h004, 8'h0A);
		@(posedge clk_in);
		irq <= 4'h0;
		repeat (2) @(negedge clk_in);
		chk(8'(irq_n), 8'h01);
		// counter transfer and channel reset
		wr(11'h105, 8'h00);
		chk({srst, counter_transfer_in_progress}, 8'h02);
		rd(11'h105, 8'h01);
		@(posedge clk_in);
		done <= 4'h2;
		@(posedge clk_in);
		done <= 4'h0;
		rd(11'h105, 8'h00);
		wr(11'h105, 8'h80);
		chk({srst, counter_transfer_in_progress}, 8'h20);
		wr(11'h002, 8'h11);
		rd(11'h002, 8'h11);
		wr(11'h005, 8'h80);
		wr(11'h002, 8'h13);
		rd(11'h002, 8'h00);
		wr(11'h005, 8'h00);
		rd(11'h002, 8'h11);
		chk({srst, counter_transfer_in_progress}, 8'h21);
		@(posedge clk_in);
		done <= 4'h1;
		@(posedge clk_in);
		done <= 4'h0;
		repeat (2) @(negedge clk_in);
		chk({srst, counter_transfer_in_progress}, 8'h20);
		// hardware reset in mid-run
		@(posedge clk_in);
		reset_n_in <= 1'b0;
		repeat (2) @(negedge clk_in);
		chk({srst, counter_transfer_in_progress}, 8'h00);
		@(posedge clk_in);
		reset_n_in <= 1'b1;
		rd(11'h002, 8'h00);
		results();
	end
endmodule
bind qpgcr_global_regs qpgcr_global_regs_checker #(.NUM_CH(NUM_CH)) chk_i (
	.clk_in(clk_in),
	.reset_n_in(reset_n_in),
	.wr_n_in(wr_n_in),
	.channel_irq_pending_in(channel_irq_pending_in),
	.clock_synth_irq_pending_in(clock_synth_irq_pending_in),
	.irq_out_n(irq_out_n),
	.transmit_bus_address_in(transmit_bus_address_in),
	.tx_channel_select_out(tx_channel_select_out),
	.cell_or_packet_mode_out(cell_or_packet_mode_out),
	.sys_if_output_enable_out(sys_if_output_enable_out),
	.channel_soft_reset_out(channel_soft_reset_out),
	.counter_transfer_start_out(counter_transfer_start_out),
	.counter_transfer_in_progress_out(counter_transfer_in_progress_out),
	.counter_transfer_done_in(counter_transfer_done_in)
);
`default_nettype wire
